// ==== core/arc_pkg.sv ====
// Constants, types and register map of the auto-recloser control block
// Behaviour
// [R1] A request during shot reclaim advances to the next enabled shot, else final trip.
// [R2] A shot uses arcing or discrimination timing, never both.
// [R3] With arcing, a request in reclaim runs the arcing timer; expiry fails the shot.
// [R4] If the request drops early, arcing pauses and reclaim timing continues.
// [R5] Shot reclaim expiry means success: go to general reclaim or ready.
// [R6] Arcing time accumulates within a shot and is compared with the fail window.
// [R7] Discrimination timer starts together with reclaim timer after the reclose.
// [R8] A request inside the discrimination window halts the recloser, no more commands.
// [R9] After a halt the operator resets the recloser and closes the breaker manually.
// [R10] Drive breaker open and close commands plus status indications.
// [R11] Every edge of commands and operational signals emits a millisecond time-stamped event; the code emits only edges whose evt_en bit is set.
// [R12] Per-shot and per-request cumulative counters, clearable on command.
// [R13] An object control failure during open or close is accepted and acted on.
// [R14] Manual open or close during an active sequence resets the sequence; the code ignores both while opening, and manual close while closing.
// [R15] Manual close during dead time with fault present goes to general reclaim, then lock-out.
// [R16] Setting changes take effect even during a running sequence.
// [R17] Input status changes produce events, each type enabled by configuration.
// [R18] Sequence start opens the collector breaker; it stays open until sequence end.
// [R19] Collector close permission only after reclaim of a successful sequence.
// [R20] The breaker object is configured in object control before enabling the recloser.
// [R21] Fault during general reclaim leads straight to final trip, then lock-out.
// [R22] A timer set to zero is skipped as if already elapsed.
// [R23] Critical lock request forces the locked state from any step.
// [R24] All timers run on a common millisecond tick with inclusive expiry.
package arc_pkg;
    localparam int NSHOT = 5;
    localparam int NREQ = 5;
    localparam int TW = 21;
    localparam int CW = 16;
    localparam int AW = 8;
    localparam int EVW = 16;
    localparam int DIVW = 18;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

    localparam logic [AW-1:0] A_CTRL = 8'h00;
    localparam logic [AW-1:0] A_STATUS = 8'h04;
    localparam logic [AW-1:0] A_GRECL = 8'h08;
    localparam logic [AW-1:0] A_EVTEN = 8'h0C;
    localparam logic [AW-1:0] A_STAMP = 8'h10;
    localparam logic [AW-1:0] A_SHOT_LO = 8'h20;
    localparam logic [AW-1:0] A_SHOT_HI = 8'h70;
    localparam logic [AW-1:0] A_SCNT_LO = 8'h80;
    localparam logic [AW-1:0] A_SCNT_HI = 8'h94;
    localparam logic [AW-1:0] A_RCNT_LO = 8'hA0;
    localparam logic [AW-1:0] A_RCNT_HI = 8'hB4;
    localparam logic [2:0] SHOT_BASE_IDX = 3'h2;
    localparam logic [1:0] SUB_CFG = 2'h0;
    localparam logic [1:0] SUB_DEAD = 2'h1;
    localparam logic [1:0] SUB_ACT = 2'h2;

    localparam int C_EN = 0;
    localparam int C_GRECL = 1;
    localparam int C_MASTER = 2;
    localparam int C_CLR = 8;

    localparam logic [1:0] MODE_ARC = 2'h1;
    localparam logic [1:0] MODE_DISC = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_OPENING = 4'b0001,
        ST_DEAD = 4'b0010,
        ST_CLOSING = 4'b0011,
        ST_RECLAIM = 4'b0100,
        ST_GRECL = 4'b0101,
        ST_FTRIP = 4'b0110,
        ST_LOCKOUT = 4'b0111,
        ST_HALTED = 4'b1000
    } arc_state_t;

    typedef struct packed {
        arc_state_t st;
        logic [2:0] shot;
        logic [2:0] src;
        logic [TW-1:0] t;
        logic [TW-1:0] arc;
        logic lock_after;
        logic permit;
        logic coll_open;
        logic [2:0] ctrl;
        logic [TW-1:0] grecl;
        logic [EVW-1:0] evt_en;
        logic [NSHOT-1:0] shot_en;
        logic [NSHOT-1:0][1:0] mode;
        logic [NSHOT-1:0][TW-1:0] dead;
        logic [NSHOT-1:0][TW-1:0] act;
        logic [NSHOT-1:0][TW-1:0] recl;
        logic [NSHOT-1:0][CW-1:0] scnt;
        logic [NREQ-1:0][CW-1:0] rcnt;
        logic [DIVW-1:0] div;
        logic [31:0] stamp;
        logic [EVW-1:0] ev_prev;
        logic evt_valid;
        logic [EVW-1:0] evt_chg;
        logic [EVW-1:0] evt_lvl;
        logic [31:0] evt_stamp;
        logic awg;
        logic [AW-1:0] awa;
        logic wg;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } arc_regs_t;
endpackage

// ==== core/arc_recloser.sv ====
// Auto-recloser sequence control with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module arc_recloser
    import arc_pkg::*;
#(
    parameter int MS_CYCLES = TICK_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ar_on,
    input wire logic [NREQ-1:0] req,
    input wire logic critical_lock_request,
    input wire logic manual_reset,
    input wire logic brk_closed,
    input wire logic obj_fail,
    input wire logic man_open,
    input wire logic man_close,
    output logic obj_open,
    output logic obj_close,
    output logic running,
    output logic in_progress,
    output logic [NREQ-1:0] req_on,
    output logic [NSHOT-1:0] shot_running,
    output logic seq_finished,
    output logic locked,
    output logic halted,
    output logic general_reclaim_active,
    output logic collector_open,
    output logic collector_close_permit,
    output logic evt_valid,
    output logic [EVW-1:0] evt_chg,
    output logic [EVW-1:0] evt_lvl,
    output logic [31:0] evt_stamp
);
    arc_regs_t s_r;
    arc_regs_t s_nxt;

    // Lowest enabled shot index at or above 'from'; bit 3 flags a hit
    function automatic logic [3:0] find_shot(input logic [NSHOT-1:0] en, input logic [2:0] from);
        find_shot = '0;
        for (int i = NSHOT - 1; i >= 0; i--) begin
            if (en[i] && 3'(i) >= from) begin
                find_shot = {1'b1, 3'(i)};
            end
        end
    endfunction

    function automatic logic addr_ok(input logic [AW-1:0] a);
        addr_ok = (a == A_CTRL) || (a == A_STATUS) || (a == A_GRECL) || (a == A_EVTEN) || (a == A_STAMP)
            || (a >= A_SHOT_LO && a < A_SHOT_HI) || (a >= A_SCNT_LO && a < A_SCNT_HI)
            || (a >= A_RCNT_LO && a < A_RCNT_HI);
    endfunction

    function automatic logic [31:0] rd(input arc_regs_t r, input logic [AW-1:0] a);
        logic [2:0] i;
        logic [2:0] k;
        i = a[6:4] - SHOT_BASE_IDX;
        k = a[4:2];
        rd = '0;
        if (a == A_CTRL) begin
            rd = {29'h0000_0000, r.ctrl};
        end else if (a == A_STATUS) begin
            rd = {19'h0_0000, r.lock_after, r.coll_open, r.permit, r.src, r.shot, r.st};
        end else if (a == A_GRECL) begin
            rd = 32'(r.grecl);
        end else if (a == A_EVTEN) begin
            rd = 32'(r.evt_en);
        end else if (a == A_STAMP) begin
            rd = r.stamp;
        end else if (a >= A_SHOT_LO && a < A_SHOT_HI) begin
            unique case (a[3:2])
                SUB_CFG: rd = {29'h0000_0000, r.mode[i], r.shot_en[i]};
                SUB_DEAD: rd = 32'(r.dead[i]);
                SUB_ACT: rd = 32'(r.act[i]);
                default: rd = 32'(r.recl[i]);
            endcase
        end else if (a >= A_SCNT_LO && a < A_SCNT_HI) begin
            rd = 32'(r.scnt[k]);
        end else if (a >= A_RCNT_LO && a < A_RCNT_HI) begin
            rd = 32'(r.rcnt[k]);
        end
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = st[b] ? d[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction

    logic tick;
    logic ar_en;
    logic hit;
    logic [2:0] pr;
    logic [3:0] first;
    logic [3:0] nxt;
    logic [EVW-1:0] ev_now;
    logic [31:0] wd;
    logic [2:0] wi;
    logic [2:0] wk;
    logic st_running;

    assign st_running = (s_r.st == ST_OPENING) || (s_r.st == ST_DEAD) || (s_r.st == ST_CLOSING)
        || (s_r.st == ST_RECLAIM);
    // [R10]
    assign obj_open = (s_r.st == ST_OPENING) || (s_r.st == ST_FTRIP);
    assign obj_close = (s_r.st == ST_CLOSING);
    assign running = st_running;
    assign in_progress = (s_r.st == ST_DEAD);
    assign req_on = st_running ? NREQ'(1 << s_r.src) : '0;
    assign shot_running = st_running ? NSHOT'(1 << s_r.shot) : '0;
    assign locked = (s_r.st == ST_LOCKOUT);
    assign halted = (s_r.st == ST_HALTED);
    assign general_reclaim_active = (s_r.st == ST_GRECL);
    assign collector_open = s_r.coll_open;
    assign collector_close_permit = s_r.permit;
    assign evt_valid = s_r.evt_valid;
    assign evt_chg = s_r.evt_chg;
    assign evt_lvl = s_r.evt_lvl;
    assign evt_stamp = s_r.evt_stamp;
    assign s_axi_awready = !s_r.awg;
    assign s_axi_wready = !s_r.wg;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = !s_r.rvalid;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;

    always_comb begin
        s_nxt = s_r;
        // One millisecond base shared by every timer and the time stamp
        tick = (s_r.div == DIVW'(MS_CYCLES - 1)); // [R24]
        s_nxt.div = tick ? '0 : s_r.div + 1'b1;
        s_nxt.stamp = s_r.stamp + 32'(tick); // [R11]
        if (tick && !(&s_r.t)) begin
            s_nxt.t = s_r.t + 1'b1;
        end
        ar_en = s_r.ctrl[C_EN] && ar_on;
        hit = |req;
        pr = '0;
        for (int j = NREQ - 1; j >= 0; j--) begin
            if (req[j]) begin
                pr = 3'(j);
            end
        end
        first = find_shot(s_r.shot_en, 3'h0);
        nxt = find_shot(s_r.shot_en, s_r.shot + 3'h1);

        // Bus side: address and data taken in either order
        if (s_axi_awvalid && !s_r.awg) begin
            s_nxt.awg = 1'b1;
            s_nxt.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_r.wg) begin
            s_nxt.wg = 1'b1;
            s_nxt.wd = s_axi_wdata;
            s_nxt.ws = s_axi_wstrb;
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        wd = merge(rd(s_r, s_r.awa), s_r.wd, s_r.ws);
        wi = s_r.awa[6:4] - SHOT_BASE_IDX;
        wk = s_r.awa[4:2];
        if (s_r.awg && s_r.wg && !s_r.bvalid) begin
            s_nxt.awg = 1'b0;
            s_nxt.wg = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = addr_ok(s_r.awa) ? RESP_OKAY : RESP_DECERR;
            if (s_r.awa == A_CTRL) begin
                s_nxt.ctrl = wd[2:0];
                if (wd[C_CLR] && s_r.ws[1]) begin
                    s_nxt.scnt = '0; // [R12]
                    s_nxt.rcnt = '0;
                end
            end else if (s_r.awa == A_GRECL) begin
                s_nxt.grecl = wd[TW-1:0];
            end else if (s_r.awa == A_EVTEN) begin
                s_nxt.evt_en = wd[EVW-1:0];
            end else if (s_r.awa >= A_SHOT_LO && s_r.awa < A_SHOT_HI) begin
                unique case (s_r.awa[3:2])
                    SUB_CFG: begin
                        s_nxt.shot_en[wi] = wd[0];
                        // One two-bit field, so arcing and discrimination exclude each other
                        s_nxt.mode[wi] = wd[2:1]; // [R2]
                    end
                    SUB_DEAD: s_nxt.dead[wi] = wd[TW-1:0];
                    SUB_ACT: s_nxt.act[wi] = wd[TW-1:0];
                    default: s_nxt.recl[wi] = wd[TW-1:0];
                endcase
            end
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_r.rvalid) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = addr_ok(s_axi_araddr) ? rd(s_r, s_axi_araddr) : '0;
            s_nxt.rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
        end

        // Sequence; settings are read live each cycle, never latched per sequence [R16]
        if (!ar_en) begin
            s_nxt.st = ST_IDLE;
        end else if (critical_lock_request) begin
            s_nxt.st = ST_LOCKOUT; // [R23]
        end else begin
            unique case (s_r.st)
                ST_IDLE: begin
                    if (hit && brk_closed && first[3]) begin
                        s_nxt.st = ST_OPENING;
                        s_nxt.shot = first[2:0];
                        s_nxt.src = pr;
                        s_nxt.rcnt[pr] = s_nxt.rcnt[pr] + 1'b1; // [R12]
                        s_nxt.coll_open = s_r.ctrl[C_MASTER]; // [R18]
                        s_nxt.permit = 1'b0;
                    end
                end
                ST_OPENING: begin
                    if (obj_fail) begin
                        s_nxt.st = ST_LOCKOUT; // [R13]
                    end else if (!brk_closed) begin
                        s_nxt.st = ST_DEAD;
                    end
                end
                ST_DEAD: begin
                    if (man_close && hit) begin
                        s_nxt.st = ST_GRECL; // [R15]
                        s_nxt.lock_after = 1'b1;
                    end else if (man_open || man_close) begin
                        s_nxt.st = ST_IDLE; // [R14]
                    end else if (s_r.t >= s_r.dead[s_r.shot]) begin
                        // Zero setting expires on entry [R22]
                        s_nxt.st = ST_CLOSING;
                        s_nxt.scnt[s_r.shot] = s_nxt.scnt[s_r.shot] + 1'b1; // [R12]
                    end
                end
                ST_CLOSING: begin
                    if (obj_fail) begin
                        s_nxt.st = ST_LOCKOUT; // [R13]
                    end else if (man_open) begin
                        s_nxt.st = ST_IDLE; // [R14]
                    end else if (brk_closed) begin
                        // Reclaim and discrimination share the one timer, so they start together
                        s_nxt.st = ST_RECLAIM; // [R7]
                    end
                end
                ST_RECLAIM: begin
                    if (man_open || man_close) begin
                        s_nxt.st = ST_IDLE; // [R14]
                    end else if (hit && s_r.mode[s_r.shot] == MODE_DISC && s_r.t < s_r.act[s_r.shot]) begin
                        s_nxt.st = ST_HALTED; // [R8]
                    end else if (hit && s_r.mode[s_r.shot] == MODE_ARC && s_r.arc < s_r.act[s_r.shot]) begin
                        // Accumulates only while the request stands, kept between activations
                        if (tick) begin
                            s_nxt.arc = s_r.arc + 1'b1; // [R3] [R4] [R6]
                        end
                    end else if (hit) begin
                        if (nxt[3]) begin
                            s_nxt.st = ST_OPENING; // [R1] [R3]
                            s_nxt.shot = nxt[2:0];
                        end else begin
                            s_nxt.st = ST_FTRIP; // [R1]
                        end
                    end else if (s_r.t >= s_r.recl[s_r.shot]) begin
                        if (s_r.ctrl[C_GRECL]) begin
                            s_nxt.st = ST_GRECL; // [R5]
                        end else begin
                            s_nxt.st = ST_IDLE; // [R5]
                            s_nxt.permit = s_r.ctrl[C_MASTER]; // [R19]
                        end
                    end
                end
                ST_GRECL: begin
                    if (hit && !s_r.lock_after) begin
                        s_nxt.st = ST_FTRIP; // [R21]
                    end else if (s_r.t >= s_r.grecl) begin
                        if (s_r.lock_after) begin
                            s_nxt.st = ST_LOCKOUT; // [R15]
                        end else begin
                            s_nxt.st = ST_IDLE;
                            s_nxt.permit = s_r.ctrl[C_MASTER]; // [R19]
                        end
                    end
                end
                ST_FTRIP: begin
                    if (!brk_closed || obj_fail) begin
                        s_nxt.st = ST_LOCKOUT;
                    end
                end
                ST_LOCKOUT, ST_HALTED: begin
                    // Halt issues no breaker command; operator must reset and close by hand
                    if (manual_reset) begin
                        s_nxt.st = ST_IDLE; // [R9]
                    end
                end
                default: s_nxt.st = ST_IDLE;
            endcase
        end
        if (s_nxt.st != s_r.st) begin
            s_nxt.t = '0;
        end
        if (s_nxt.st == ST_OPENING && (s_r.st != ST_OPENING)) begin
            s_nxt.arc = '0;
        end
        // Collector stays open until the sequence is over [R18]
        if (s_nxt.st == ST_IDLE) begin
            s_nxt.coll_open = 1'b0;
            s_nxt.lock_after = 1'b0;
        end

        // One event word per cycle carries every masked edge, so none is lost
        ev_now = {ar_on, manual_reset, critical_lock_request, req, seq_finished, general_reclaim_active,
            halted, locked, in_progress, running, obj_close, obj_open};
        s_nxt.ev_prev = ev_now;
        s_nxt.evt_chg = (ev_now ^ s_r.ev_prev) & s_r.evt_en; // [R11] [R17]
        s_nxt.evt_valid = |s_nxt.evt_chg;
        s_nxt.evt_lvl = ev_now;
        s_nxt.evt_stamp = s_r.stamp;
    end

    assign seq_finished = (s_r.st == ST_RECLAIM) && !nxt[3];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== verification/arc_recloser_monitor.sv ====
// Port-level property checker for the auto-recloser
`timescale 1ns/1ps
`default_nettype none
module arc_recloser_monitor
    import arc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic critical_lock_request,
    input wire logic brk_closed,
    input wire logic [NREQ-1:0] req,
    input wire logic obj_open,
    input wire logic obj_close,
    input wire logic running,
    input wire logic locked,
    input wire logic halted,
    input wire logic [NREQ-1:0] req_on,
    input wire logic [NSHOT-1:0] shot_running,
    input wire logic evt_valid,
    input wire logic [EVW-1:0] evt_chg,
    input wire logic [EVW-1:0] evt_lvl
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_close_seen;
        obj_close && brk_closed;
    endsequence
    sequence s_open_evt;
        evt_valid && evt_chg[0];
    endsequence
    a_cmd_exclusive: assert property (!(obj_open && obj_close))
        else $error("open and close ordered together");
    a_close_drop: assert property (s_close_seen |=> !obj_close)
        else $error("close order kept after breaker closed");
    a_halt_silent: assert property (halted |-> !obj_open && !obj_close)
        else $error("breaker order while halted");
    a_crit_lock: assert property (critical_lock_request |-> ##[1:2] locked)
        else $error("critical request did not lock");
    a_evt_open: assert property (s_open_evt |-> evt_lvl[0] == $past(obj_open) && $past(obj_open) != $past(obj_open, 2))
        else $error("open order event wrong");
    a_evt_close: assert property (evt_valid && evt_chg[1] |-> evt_lvl[1] == $past(obj_close))
        else $error("close order event wrong");
    a_evt_req: assert property (evt_valid && evt_chg[8] |-> evt_lvl[8] == $past(req[0]))
        else $error("request event wrong");
    a_busy_shot: assert property (running |-> $onehot(shot_running) && $onehot(req_on))
        else $error("shot or source not one-hot");
endmodule
bind arc_recloser arc_recloser_monitor u_mon (.*);
`default_nettype wire

// ==== verification/arc_breaker_model.sv ====
// Behavioural breaker that follows open and close orders after a travel delay
`timescale 1ns/1ps
`default_nettype none
module arc_breaker_model #(
    parameter int DLY = 4
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic obj_open,
    input wire logic obj_close,
    input wire logic man_open,
    input wire logic man_close,
    output var logic brk_closed
);
    int cnt = 0;
    always @(posedge aclk) begin
        if (!aresetn) begin
            brk_closed <= 1'b1; // Object set up and closed before enabling
            cnt <= 0;
        end else if (man_open || man_close) begin
            brk_closed <= man_close; // Operator acts directly, no travel modelled
            cnt <= 0;
        end else if ((obj_open && brk_closed) || (obj_close && !brk_closed)) begin
            cnt <= cnt + 1;
            if (cnt == DLY) brk_closed <= !brk_closed;
        end else begin
            cnt <= 0;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb_arc_recloser.sv ====
// Self-checking testbench for the auto-recloser
`timescale 1ns/1ps
`default_nettype none
module tb_arc_recloser;
    import arc_pkg::*;
    localparam int RUN = 0, OPN = 1, CLS = 2, DED = 3, LCK = 4, HLT = 5, GRC = 6, SH2 = 7;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, evt_stamp;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, evt_valid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic ar_on = 1'b1;
    logic [NREQ-1:0] req = '0, req_on;
    logic [4:0] pls = '0;
    wire logic critical_lock_request, obj_fail, man_open, man_close, manual_reset;
    logic brk_closed, obj_open, obj_close, running, in_progress, seq_finished, locked, halted;
    logic general_reclaim_active, collector_open, collector_close_permit;
    logic [NSHOT-1:0] shot_running;
    logic [EVW-1:0] evt_chg, evt_lvl;
    int error_cnt = 0, num_checks = 0;
    wire logic [7:0] obs = {shot_running[1], general_reclaim_active, halted, locked, in_progress,
                            obj_close, obj_open, running};
    assign {critical_lock_request, obj_fail, man_open, man_close, manual_reset} = pls;
    // Short millisecond keeps every timer within a few hundred cycles
    arc_recloser #(.MS_CYCLES(10)) uut (.*);
    arc_breaker_model #(.DLY(4)) u_brk (.*);
    always #2.5 aclk = ~aclk;
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Ready sampled mid-cycle equals what the next rising edge sees
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ah, wh, b;
        logic [1:0] r;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        b = 1'b0;
        while (!b) begin
            @(negedge aclk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk(36'({b, r}), 36'({1'b1, er}));
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ah, b;
        logic [1:0] r;
        logic [31:0] d;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        b = 1'b0;
        while (!b) begin
            @(negedge aclk);
            ah = s_axi_arvalid && s_axi_arready;
            b = s_axi_rvalid;
            r = s_axi_rresp;
            d = s_axi_rdata;
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        chk(36'({b, r, d}), 36'({1'b1, er, e}));
    endtask
    task automatic wt(input int k, input logic v, input int lim);
        @(negedge aclk);
        for (int i = 0; i < lim && obs[k] !== v; i++) @(negedge aclk);
        chk(36'(obs[k]), 36'(v));
    endtask
    task automatic setreq(input logic v);
        @(posedge aclk);
        req[0] <= v;
    endtask
    task automatic pulse(input int k);
        @(posedge aclk);
        pls[k] <= 1'b1;
        @(posedge aclk);
        pls[k] <= 1'b0;
    endtask
    task automatic fire;
        setreq(1'b1);
        wt(OPN, 1'b1, 5);
        wt(DED, 1'b1, 20);
        chk(36'(collector_open), 36'(1));
        setreq(1'b0);
        wt(CLS, 1'b1, 40);
        wt(CLS, 1'b0, 20);
    endtask
    task automatic recover;
        setreq(1'b0);
        pulse(0);
        pulse(1);
        wt(LCK, 1'b0, 10);
    endtask
    // Request held while an operator, fault or critical lock input strikes at a given step
    task automatic abort(input int p, input int at, input int k, input logic v);
        setreq(1'b1);
        wt(at, 1'b1, 20);
        pulse(p);
        wt(k, v, 60);
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_STATUS, 32'h0, RESP_OKAY);
        rd(8'hFC, 32'h0, RESP_DECERR);
        wr(8'hFC, 32'h1, RESP_DECERR);
        wr(A_CTRL, 32'h5, RESP_OKAY);
        wr(A_EVTEN, 32'hFFFF, RESP_OKAY);
        wr(8'h20, 32'h3, RESP_OKAY);
        wr(8'h24, 32'h2, RESP_OKAY);
        wr(8'h28, 32'h3, RESP_OKAY);
        wr(8'h2C, 32'h14, RESP_OKAY);
        wr(8'h30, 32'h1, RESP_OKAY);
        wr(8'h3C, 32'h2, RESP_OKAY);
        $display("setup done");
        fire();
        wt(RUN, 1'b0, 250);
        chk(36'(collector_close_permit), 36'(1));
        rd(A_SCNT_LO, 32'h1, RESP_OKAY);
        rd(A_RCNT_LO, 32'h1, RESP_OKAY);
        $display("clean reclose done");
        fire();
        setreq(1'b1);
        repeat (19) @(posedge aclk);
        setreq(1'b0);
        repeat (9) @(posedge aclk);
        @(negedge aclk);
        chk(36'(shot_running), 36'(5'b00001));
        setreq(1'b1);
        wt(SH2, 1'b1, 25);
        wt(LCK, 1'b1, 400);
        recover();
        $display("arcing done");
        wr(8'h20, 32'h5, RESP_OKAY);
        fire();
        setreq(1'b1);
        wt(HLT, 1'b1, 20);
        repeat (40) @(posedge aclk);
        chk(36'({obj_open, obj_close}), 36'(2'b00));
        recover();
        wt(HLT, 1'b0, 5);
        $display("discrimination done");
        wr(8'h24, 32'h1E, RESP_OKAY);
        wr(A_GRECL, 32'h2, RESP_OKAY);
        abort(1, DED, GRC, 1'b1);
        wt(LCK, 1'b1, 40);
        recover();
        abort(2, DED, RUN, 1'b0);
        recover();
        abort(3, OPN, LCK, 1'b1);
        recover();
        abort(4, DED, LCK, 1'b1);
        recover();
        $display("aborts done");
        wr(A_CTRL, 32'h101, RESP_OKAY);
        rd(A_SCNT_LO, 32'h0, RESP_OKAY);
        rd(A_RCNT_LO, 32'h0, RESP_OKAY);
        rd(A_CTRL, 32'h1, RESP_OKAY);
        $display("counter clear done");
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        wrap_up();
    end
endmodule
`default_nettype wire
